// File: hdl/tdm_pkg.sv
// Constants, types and helpers of the transmitter diagnostics monitor.
// Assumes one 25 MHz clock; temperatures and values in 0.1 degC steps.
// Behaviour
// - Present only the highest-ranked active fault class
// - Interrupts other than undervoltage report event and force alarm current unless undervoltage is present
// - Hardware faults: class 1, status, alarm, red
// - Undervoltage: class 1, below 3.6 mA, no status
// - Sensor faults: class 2, status, alarm, red flashing
// - Electronics temperature interrupt needs 3 degC overshoot
// - Sensor-limit warning raised as soon as crossed
// - Sensor-limit interrupt once overshoot exceeds 2 percent
// - Warnings: status bit, output unchanged, green LED
// - Temperature error forces fault current, survives power
// - Torn configuration: fault bit, red until reload
// - Electronics meter: 9 ambient bins, not user-resettable
// - Meters advance only in measuring mode
// - Value meter: 9 bins, clears on sensor change
// - Meters copied to NVM hourly, restored later
// - Two min/max pairs; only value pair clears
// - Simulation settings volatile, off after restart
// - Simulation replaces sensor inputs
// - No temperature simulation with internal cold junction
// - Ramp sweeps start to end, width from steps
// - Ramp steps per duration; output tracks value
package tdm_pkg;
  // ********************************************************
  // Timing
  // ********************************************************
  localparam longint unsigned CLK_HZ         = 25_000_000;
  localparam longint unsigned HOUR_S         = 3600;
  localparam longint unsigned HOUR_CYC       = CLK_HZ * HOUR_S;
  localparam longint unsigned FLASH_HALF_MS  = 250;  // 2 Hz blink
  localparam longint unsigned FLASH_HALF_CYC = CLK_HZ / 1000 * FLASH_HALF_MS;
  // ********************************************************
  // Sizes, limits and reset values
  // ********************************************************
  localparam int          VAL_W     = 16;
  localparam int          NBIN      = 9;
  localparam int          NCELL     = 2 * NBIN;
  localparam int          ET_MARGIN = 30;  // 3.0 degC
  localparam int          LIM_PCT   = 2;
  localparam int          PCT_DEN   = 100;
  localparam int          ET_BIN_LO = -400;
  localparam int          ET_BIN_HI = 850;
  localparam logic [31:0] HRS_RST   = 32'h0000_0000;
  // Status bit positions
  localparam int HS_EFAULT  = 0;
  localparam int HS_SFAULT  = 1;
  localparam int HS_W_RANGE = 2;
  localparam int HS_W_SAT   = 3;
  localparam int HS_W_PVLIM = 4;
  localparam int HS_W_ET    = 5;
  localparam int HS_W       = 6;
  localparam logic [HS_W-1:0] HS_RST = 6'h00;
  // ********************************************************
  // Types
  // ********************************************************
  typedef enum logic [1:0] {ao_meas, ao_alarm, ao_under} tdm_ao_t;
  typedef enum logic [1:0] {sim_off, sim_fixed, sim_ramp} tdm_sim_t;
  typedef enum logic [1:0] {rmp_idle, rmp_div, rmp_run} tdm_rmp_t;
  typedef enum logic [3:0] {
    flt_none, flt_ram, flt_flash, flt_wdog, flt_edef, flt_etemp,
    flt_uv, flt_cfg, flt_tlatch, flt_break, flt_short, flt_pvlim
  } tdm_flt_t;
  // ********************************************************
  // Helpers
  // ********************************************************
  // Bin 0..8: eight equal slices from lo, values at or above hi in 8
  function automatic logic [3:0] tdm_bin(input int v, input int lo, input int hi);
    int w;
    logic [3:0] b;
    w = (hi - lo) >>> 3;
    b = 4'h0;
    for (int k = 1; k < NBIN; k++) begin
      if (v >= lo + k * w) b = 4'(k);
    end
    return b;
  endfunction
  function automatic int tdm_abs(input int v);
    return (v < 0) ? -v : v;
  endfunction
endpackage

// File: hdl/tdm_monitor.sv
`timescale 1ns/1ps
// Fault priority, alarm output, LED and status bits, runtime meters,
// min/max pointers and value simulation of the transmitter.
// Assumes synchronous inputs; NVM engine and HART stack sit outside.
module tdm_monitor
  import tdm_pkg::*;
#(
  parameter int              DW           = VAL_W,
  parameter longint unsigned HOUR_CYCLES  = HOUR_CYC,
  parameter longint unsigned FLASH_CYCLES = FLASH_HALF_CYC
) (
  input  logic                 clk,
  input  logic                 nrst,
  input  logic                 ram_err,
  input  logic                 flash_err,
  input  logic                 wdog_err,
  input  logic                 elec_defect,
  input  logic                 supply_low,
  input  logic                 sensor_break,
  input  logic                 sensor_short,
  input  logic                 sat_warn,
  input  logic                 meas_tick,
  input  logic signed [DW-1:0] primary_value,
  input  logic signed [DW-1:0] elec_temp,
  input  logic signed [DW-1:0] pv_lo_lim,
  input  logic signed [DW-1:0] pv_hi_lim,
  input  logic signed [DW-1:0] rng_lo,
  input  logic signed [DW-1:0] rng_hi,
  input  logic signed [DW-1:0] et_lo_lim,
  input  logic signed [DW-1:0] et_hi_lim,
  input  logic                 sensor_chg,
  input  logic                 pv_mm_clr,
  input  logic                 tc_icjc,
  input  logic                 temp_err_nv,
  input  logic                 temp_err_clr,
  input  logic                 cfg_torn,
  input  logic                 cfg_reload_ok,
  input  logic                 sim_load,
  input  tdm_sim_t             sim_pv_mode,
  input  tdm_sim_t             sim_et_mode,
  input  logic signed [DW-1:0] sim_pv_fix,
  input  logic signed [DW-1:0] sim_et_fix,
  input  logic signed [DW-1:0] rmp_start,
  input  logic signed [DW-1:0] rmp_end,
  input  logic        [DW-1:0] rmp_steps,
  input  logic        [31:0]   rmp_dur,
  input  logic                 ld_valid,
  input  logic        [4:0]    ld_idx,
  input  logic        [31:0]   ld_data,
  input  logic        [4:0]    rd_idx,
  output tdm_flt_t             flt_code_q,
  output logic        [1:0]    flt_cls_q,
  output tdm_ao_t              ao_mode_q,
  output logic signed [DW-1:0] ao_value_q,
  output logic                 led_red_q,
  output logic                 led_green_q,
  output logic     [HS_W-1:0]  hart_stat_q,
  output logic                 temp_err_q,
  output logic                 cfg_err_q,
  output logic                 sim_active_q,
  output logic signed [DW-1:0] pv_min_q,
  output logic signed [DW-1:0] pv_max_q,
  output logic signed [DW-1:0] et_min_q,
  output logic signed [DW-1:0] et_max_q,
  output logic        [31:0]   rd_hours_q,
  output logic                 sav_valid_q,
  output logic        [4:0]    sav_idx_q,
  output logic        [31:0]   sav_data_q
);
  // ********************************************************
  // Parameter checks
  // ********************************************************
  if (DW < 8 || DW > 30) $error("DW must lie in 8..30");
  if (HOUR_CYCLES < NCELL + 2 || HOUR_CYCLES >= 64'h100_0000_0000) $error("bad HOUR_CYCLES");
  if (FLASH_CYCLES < 2 || FLASH_CYCLES >= 64'h1_0000_0000) $error("bad FLASH_CYCLES");

  localparam logic signed [DW-1:0] VMAX = {1'b0, {(DW-1){1'b1}}};
  localparam logic signed [DW-1:0] VMIN = {1'b1, {(DW-1){1'b0}}};

  // ********************************************************
  // Simulation settings, volatile only
  // ********************************************************
  tdm_sim_t             sim_pv_q, sim_et_q, sim_et_d;
  logic signed [DW-1:0] rs_start_q, rmp_val_q;
  logic                 rs_up_q;
  logic        [DW-1:0] rs_n_q, rmp_w_q, rmp_n_q, quo_q, rem_q;
  logic        [31:0]   rs_dur_q, rmp_t_q;
  tdm_rmp_t             rmp_st_q;
  logic        [4:0]    div_cnt_q;
  // Internal cold junction blocks and cancels temperature simulation
  assign sim_et_d = tc_icjc ? sim_off : (sim_load ? sim_et_mode : sim_et_q);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sim_pv_q <= sim_off;
      sim_et_q <= sim_off;
    end else begin
      sim_pv_q <= sim_load ? sim_pv_mode : sim_pv_q;
      sim_et_q <= sim_et_d;
    end
  end
  wire sim_act = (sim_pv_q != sim_off) || (sim_et_q != sim_off);
  wire any_rmp = (sim_pv_q == sim_ramp) || (sim_et_q == sim_ramp);

  // ********************************************************
  // Ramp generator: one divider pass, then periodic steps
  // ********************************************************
  wire          go_up  = rmp_end >= rmp_start;
  wire [DW-1:0] span   = go_up ? DW'(rmp_end - rmp_start) : DW'(rmp_start - rmp_end);
  wire [DW-1:0] dvs    = (rs_n_q == '0) ? DW'(1) : rs_n_q;
  wire [DW:0]   dtry   = {rem_q, quo_q[DW-1]};
  wire          dge    = dtry >= {1'b0, dvs};
  wire [DW-1:0] rem_nx = dge ? DW'(dtry - {1'b0, dvs}) : DW'(dtry);
  wire [DW-1:0] quo_nx = {quo_q[DW-2:0], dge};
  wire          t_end  = rmp_t_q + 32'h1 >= rs_dur_q;
  wire          wrap   = rmp_n_q >= dvs;
  wire signed [DW-1:0] step_v = rs_up_q ? rmp_val_q + $signed(rmp_w_q)
                                        : rmp_val_q - $signed(rmp_w_q);
  // Step width is the span split over the step count
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rmp_st_q <= rmp_idle;
      {rs_start_q, rs_up_q, rs_n_q, rs_dur_q} <= '0;
      {rmp_val_q, rmp_w_q, rmp_n_q, rmp_t_q, quo_q, rem_q, div_cnt_q} <= '0;
    end else if (sim_load) begin
      rmp_st_q   <= (sim_pv_mode == sim_ramp || sim_et_mode == sim_ramp) ? rmp_div : rmp_idle;
      rs_start_q <= rmp_start;
      rs_up_q    <= go_up;
      rs_n_q     <= rmp_steps;
      rs_dur_q   <= rmp_dur;
      quo_q      <= span;
      rem_q      <= '0;
      div_cnt_q  <= '0;
    end else begin
      case (rmp_st_q)
        rmp_div: begin
          quo_q     <= quo_nx;
          rem_q     <= rem_nx;
          div_cnt_q <= div_cnt_q + 5'h1;
          if (div_cnt_q == 5'(DW - 1)) begin
            rmp_st_q  <= rmp_run;
            rmp_w_q   <= quo_nx;
            rmp_val_q <= rs_start_q;
            rmp_n_q   <= '0;
            rmp_t_q   <= '0;
          end
        end
        rmp_run: begin
          if (!any_rmp) rmp_st_q <= rmp_idle;
          rmp_t_q <= t_end ? 32'h0 : rmp_t_q + 32'h1;
          if (t_end && wrap) begin
            rmp_val_q <= rs_start_q;
            rmp_n_q   <= '0;
          end else if (t_end) begin
            rmp_val_q <= step_v;
            rmp_n_q   <= rmp_n_q + DW'(1);
          end
        end
        default: rmp_st_q <= rmp_idle;
      endcase
    end
  end

  // ********************************************************
  // Values in use: simulation overrides the sensor inputs
  // ********************************************************
  wire signed [DW-1:0] pv_u = (sim_pv_q == sim_fixed) ? sim_pv_fix :
                              (sim_pv_q == sim_ramp) ? rmp_val_q : primary_value;
  wire signed [DW-1:0] et_u = (sim_et_q == sim_fixed) ? sim_et_fix :
                              (sim_et_q == sim_ramp) ? rmp_val_q : elec_temp;
  int pv_i, et_i, pvh_i, pvl_i, eth_i, etl_i;
  assign pv_i  = int'(pv_u);
  assign et_i  = int'(et_u);
  assign pvh_i = int'(pv_hi_lim);
  assign pvl_i = int'(pv_lo_lim);
  assign eth_i = int'(et_hi_lim);
  assign etl_i = int'(et_lo_lim);

  // ********************************************************
  // Diagnostics and priority
  // ********************************************************
  wire pv_w_lim = pv_i > pvh_i || pv_i < pvl_i;
  wire pv_int   = (pv_i - pvh_i) * PCT_DEN > tdm_abs(pvh_i) * LIM_PCT ||
                  (pvl_i - pv_i) * PCT_DEN > tdm_abs(pvl_i) * LIM_PCT;
  wire et_int   = et_i >= eth_i + ET_MARGIN || et_i <= etl_i - ET_MARGIN;
  wire et_w     = et_i > eth_i || et_i < etl_i;
  wire rng_w    = pv_u > rng_hi || pv_u < rng_lo;
  // Undervoltage is class 1 but kept out of the status bit
  wire hw1 = ram_err | flash_err | wdog_err | elec_defect | et_int | cfg_err_q | temp_err_q;
  wire p1  = hw1 | supply_low;
  wire p2  = sensor_break | sensor_short | pv_int;
  tdm_flt_t flt_d;
  assign flt_d = ram_err ? flt_ram : flash_err ? flt_flash : wdog_err ? flt_wdog :
                 elec_defect ? flt_edef : et_int ? flt_etemp : supply_low ? flt_uv :
                 cfg_err_q ? flt_cfg : temp_err_q ? flt_tlatch :
                 sensor_break ? flt_break : sensor_short ? flt_short :
                 pv_int ? flt_pvlim : flt_none;
  wire [1:0] cls_d = p1 ? 2'h1 : (p2 ? 2'h2 : 2'h0);
  tdm_ao_t ao_d;
  assign ao_d = supply_low ? ao_under : ((p1 | p2) ? ao_alarm : ao_meas);
  wire [HS_W-1:0] hs_d = {et_w, pv_w_lim, sat_warn, rng_w, p2, hw1};

  // Half-period counter for the flashing red LED
  logic [31:0] fl_cnt_q;
  logic        flash_q;
  wire         fl_end = fl_cnt_q == 32'(FLASH_CYCLES - 1);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fl_cnt_q <= '0;
      flash_q  <= 1'b0;
    end else begin
      fl_cnt_q <= fl_end ? 32'h0 : fl_cnt_q + 32'h1;
      flash_q  <= flash_q ^ fl_end;
    end
  end

  // Presented fault, output mode, LED and status
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flt_code_q   <= flt_none;
      flt_cls_q    <= 2'h0;
      ao_mode_q    <= ao_meas;
      ao_value_q   <= '0;
      led_red_q    <= 1'b0;
      led_green_q  <= 1'b0;
      hart_stat_q  <= HS_RST;
      sim_active_q <= 1'b0;
    end else begin
      flt_code_q   <= flt_d;
      flt_cls_q    <= cls_d;
      ao_mode_q    <= ao_d;
      ao_value_q   <= pv_u;
      led_red_q    <= p1 | (p2 & flash_q);
      led_green_q  <= ~(p1 | p2);
      hart_stat_q  <= hs_d;
      sim_active_q <= sim_act;
    end
  end

  // Latched errors: the set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      temp_err_q <= 1'b0;
      cfg_err_q  <= 1'b0;
    end else begin
      temp_err_q <= et_int | temp_err_nv | (temp_err_q & ~temp_err_clr);
      cfg_err_q  <= cfg_torn | (cfg_err_q & ~cfg_reload_ok);
    end
  end

  // ********************************************************
  // Min/max pointer pairs
  // ********************************************************
  wire mm_clr = pv_mm_clr | sensor_chg;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {pv_min_q, et_min_q} <= {VMAX, VMAX};
      {pv_max_q, et_max_q} <= {VMIN, VMIN};
    end else begin
      if (mm_clr) begin
        pv_min_q <= VMAX;
        pv_max_q <= VMIN;
      end else if (meas_tick) begin
        pv_min_q <= (pv_u < pv_min_q) ? pv_u : pv_min_q;
        pv_max_q <= (pv_u > pv_max_q) ? pv_u : pv_max_q;
      end
      if (meas_tick) begin
        et_min_q <= (et_u < et_min_q) ? et_u : et_min_q;
        et_max_q <= (et_u > et_max_q) ? et_u : et_max_q;
      end
    end
  end

  // ********************************************************
  // Runtime meters: cells 0..8 ambient, 9..17 primary value
  // ********************************************************
  logic [39:0] hr_cnt_q;
  logic [31:0] hrs_q [NCELL];
  logic [31:0] hrs_d [NCELL];
  logic [4:0]  sav_ptr_q;
  logic        sav_run_q;
  wire         hr_tick = !sim_act && hr_cnt_q == 40'(HOUR_CYCLES - 1);
  wire [3:0]   et_bin  = tdm_bin(int'(elec_temp), ET_BIN_LO, ET_BIN_HI);
  wire [3:0]   pv_bin  = tdm_bin(int'(primary_value), pvl_i, pvh_i);
  // Restore beats a clear, which beats the hourly increment
  for (genvar i = 0; i < NCELL; i++) begin : g_cell
    wire hit = (i < NBIN) ? (4'(i) == et_bin) : (4'(i - NBIN) == pv_bin);
    assign hrs_d[i] = (ld_valid && ld_idx == 5'(i)) ? ld_data :
                      (sensor_chg && i >= NBIN) ? HRS_RST :
                      (hr_tick && hit) ? hrs_q[i] + 32'h1 : hrs_q[i];
  end
  // Hour timer stops during simulation so hours are not credited
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hr_cnt_q <= '0;
    end else if (!sim_act) begin
      hr_cnt_q <= hr_tick ? 40'h0 : hr_cnt_q + 40'h1;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NCELL; i++) hrs_q[i] <= HRS_RST;
    end else begin
      for (int i = 0; i < NCELL; i++) hrs_q[i] <= hrs_d[i];
    end
  end
  // Hourly save sweep, one cell per cycle, after the increment
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {sav_run_q, sav_ptr_q, sav_valid_q, sav_idx_q, sav_data_q} <= '0;
      rd_hours_q <= HRS_RST;
    end else begin
      sav_valid_q <= sav_run_q;
      sav_idx_q   <= sav_ptr_q;
      sav_data_q  <= (sav_ptr_q < 5'(NCELL)) ? hrs_q[sav_ptr_q] : HRS_RST;
      sav_run_q   <= hr_tick | (sav_run_q && sav_ptr_q != 5'(NCELL - 1));
      sav_ptr_q   <= sav_run_q ? sav_ptr_q + 5'h1 : 5'h0;
      rd_hours_q  <= (rd_idx < 5'(NCELL)) ? hrs_q[rd_idx] : HRS_RST;
    end
  end

  // ********************************************************
  // Assertions
  // ********************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_wrap;
    rmp_st_q == rmp_run && t_end && wrap && !sim_load && any_rmp;
  endsequence
  sequence s_cfg_hold;
    cfg_torn ##1 !cfg_reload_ok;
  endsequence
  prio_one_a: assert property (p1 && p2 |=> flt_cls_q == 2'h1)
    else $error("class 2 shown while class 1 active");
  alarm_out_a: assert property (p2 && !supply_low |=> ao_mode_q == ao_alarm)
    else $error("alarm current missing");
  hw_fault_a: assert property (wdog_err |=> hart_stat_q[HS_EFAULT] && led_red_q)
    else $error("hardware fault not shown");
  undervolt_a: assert property (supply_low && !hw1 |=> ao_mode_q == ao_under
                                && !hart_stat_q[HS_EFAULT])
    else $error("undervoltage handling wrong");
  flash_led_a: assert property (p2 && !p1 && !flash_q |=> !led_red_q)
    else $error("red LED not flashing");
  et_margin_a: assert property ($rose(temp_err_q) |-> $past(temp_err_nv) ||
                                $past(et_i) >= $past(eth_i) + ET_MARGIN ||
                                $past(et_i) <= $past(etl_i) - ET_MARGIN)
    else $error("temperature error without margin");
  pv_warn_a: assert property (pv_i > pvh_i |=> hart_stat_q[HS_W_PVLIM])
    else $error("sensor limit warning late");
  temp_hold_a: assert property (temp_err_q && !temp_err_clr |=> temp_err_q)
    else $error("temperature error dropped");
  cfg_red_a: assert property (s_cfg_hold |=> led_red_q && hart_stat_q[HS_EFAULT])
    else $error("torn configuration not shown");
  meter_hold_a: assert property (sim_act |=> $stable(hr_cnt_q))
    else $error("hour timer ran in simulation");
  icjc_block_a: assert property (tc_icjc |=> sim_et_q == sim_off)
    else $error("temperature simulation not refused");
  ramp_wrap_a: assert property (s_wrap |=> rmp_val_q == rs_start_q && rmp_n_q == '0)
    else $error("ramp did not restart");
endmodule

// File: test/tdm_host_model.sv
`timescale 1ns/1ps
// Host and NVM partner: keeps the hourly save words, sends the reset command.
// Assumes the bench asks for the command with a one-cycle clr_req.
module tdm_host_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        clr_req,
  input  wire logic        sav_valid_q,
  input  wire logic [4:0]  sav_idx_q,
  input  wire logic [31:0] sav_data_q,
  input  wire logic [4:0]  nv_idx,
  output      logic        clr_q,
  output wire logic [31:0] nv_word
);
  logic [31:0] nv_q [18];
  // NVM copy ignores nrst, since it has to outlive a power loss
  always_ff @(posedge clk) begin
    if (sav_valid_q) nv_q[sav_idx_q] <= sav_data_q;
  end
  assign nv_word = nv_q[nv_idx];
  // Reset command only when the operator explicitly asks for it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) clr_q <= 1'b0;
    else clr_q <= clr_req;
  end
endmodule

// File: test/tdm_monitor_test.sv
`timescale 1ns/1ps
// Self-checking bench of tdm_monitor with the host/NVM partner model.
// Assumes an 80-cycle hour and a 4-cycle LED blink half period.
module tdm_monitor_test
  import tdm_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic               sat_warn, meas_tick, sensor_chg, pv_mm_clr, tc_icjc, temp_err_nv;
  logic               ram_err, flash_err, wdog_err, elec_defect, supply_low, sensor_break;
  logic               sensor_short, cfg_torn, cfg_reload_ok, sim_load, ld_valid, clr_req;
  logic               led_red_q, led_green_q, temp_err_q, cfg_err_q, sim_active_q;
  logic               sav_valid_q, temp_err_clr;
  logic signed [15:0] primary_value, elec_temp, pv_lo_lim, pv_hi_lim, rng_lo, rng_hi;
  logic signed [15:0] et_lo_lim, et_hi_lim, sim_pv_fix, sim_et_fix, rmp_start, rmp_end;
  logic signed [15:0] ao_value_q, pv_min_q, pv_max_q, et_min_q, et_max_q;
  logic [15:0]        rmp_steps;
  logic [31:0]        rmp_dur, ld_data, rd_hours_q, sav_data_q, nv_word, seed;
  logic [4:0]         ld_idx, rd_idx, sav_idx_q, nv_idx;
  logic [6:0]         flt;
  logic [1:0]         flt_cls_q;
  logic [HS_W-1:0]    hart_stat_q;
  tdm_sim_t           sim_pv_mode, sim_et_mode;
  tdm_flt_t           flt_code_q;
  tdm_ao_t            ao_mode_q;
  int                 miscompares, checked, cyc, n, cnt, mn, mx, emn, emx, eb, pb;
  int                 pvs [3] = '{1001, 1020, 1021};
  tdm_flt_t codes [7] = '{flt_ram, flt_flash, flt_wdog, flt_edef, flt_uv, flt_break, flt_short};
  assign {sensor_short, sensor_break, supply_low, elec_defect, wdog_err, flash_err, ram_err} = flt;
  // Short hour and blink keep the run brief
  tdm_monitor #(.HOUR_CYCLES(80), .FLASH_CYCLES(4)) dut (.*);
  tdm_host_model host (.clk(clk), .nrst(nrst), .clr_req(clr_req), .sav_valid_q(sav_valid_q),
    .sav_idx_q(sav_idx_q), .sav_data_q(sav_data_q), .nv_idx(nv_idx), .clr_q(temp_err_clr),
    .nv_word(nv_word));
  always #20 clk = ~clk;
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      results();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Random value in lo .. lo+999
  function automatic logic signed [15:0] rnd(input int lo);
    seed = lfsr(seed);
    return 16'(lo + int'(seed % 1000));
  endfunction
  // Eight equal slices from lo, clamped to bins 0..8
  function automatic int bin(input int v, input int lo, input int hi);
    int b;
    b = (v - lo) / ((hi - lo) >>> 3);
    return (v < lo) ? 0 : ((b > 8) ? 8 : b);
  endfunction
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rdc(input logic [4:0] i, input logic [31:0] e);
    rd_idx = i;
    tick(2);
    chk("hours", rd_hours_q, e);
  endtask
  task automatic results;
    $display("checks %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Main sequence; inputs change at the falling edge only
  initial begin
    {flt, sat_warn, meas_tick, sensor_chg, pv_mm_clr, tc_icjc, temp_err_nv} = '0;
    {cfg_torn, cfg_reload_ok, sim_load, ld_valid, clr_req, ld_idx, rd_idx, nv_idx} = '0;
    {ld_data, rmp_dur, rmp_steps, rmp_start, rmp_end, sim_pv_fix, sim_et_fix} = '0;
    sim_pv_mode = sim_off;
    sim_et_mode = sim_off;
    seed = 32'h7ed1ef3c;
    {pv_lo_lim, pv_hi_lim, rng_lo, rng_hi} = {-16'sh00c8, 16'sh03e8, -16'sh0064, 16'sh0320};
    {et_lo_lim, et_hi_lim, primary_value, elec_temp} = {-16'sh0190, 16'sh0258, 32'h012c00fa};
    tick(6);
    nrst = 1'b1;
    {mn, mx, emn, emx} = {32'sd32767, -32'sd32768, 32'sd32767, -32'sd32768};
    meas_tick = 1'b1;
    repeat (8) begin
      {primary_value, elec_temp} = {rnd(-200), rnd(-400)};
      tick(1);
      mn = (primary_value < mn) ? primary_value : mn;
      mx = (primary_value > mx) ? primary_value : mx;
      emn = (elec_temp < emn) ? elec_temp : emn;
      emx = (elec_temp > emx) ? elec_temp : emx;
    end
    meas_tick = 1'b0;
    tick(1);
    chk("pv pair", {pv_min_q, pv_max_q}, {16'(mn), 16'(mx)});
    pulse(pv_mm_clr);
    tick(1);
    chk("pv clr", {pv_min_q, pv_max_q}, 32'h7fff8000);
    chk("et kept", {et_min_q, et_max_q}, {16'(emn), 16'(emx)});
    $display("test minmax done");
    {primary_value, elec_temp} = {rnd(-200), rnd(-400)};
    {pb, eb} = {bin(primary_value, -200, 1000), bin(elec_temp, -400, 850)};
    for (n = 0; n < 120 && sav_valid_q !== 1'b1; n++) tick(1);
    tick(20);
    rdc(5'(eb), 1);
    rdc(5'(9 + pb), 1);
    rdc(5'((eb + 1) % 9), 0);
    nv_idx = 5'(eb);
    tick(1);
    chk("nv", nv_word, 1);
    pulse(sensor_chg);
    rdc(5'(9 + pb), 0);
    rdc(5'(eb), 1);
    $display("test meters done");
    {primary_value, rmp_end, rmp_steps, rmp_dur} = {16'sh022b, 16'sh0064, 16'h0004, 32'h2};
    sim_pv_mode = sim_ramp;
    pulse(sim_load);
    for (n = 0; n < 60 && ao_value_q !== 16'sh0019; n++) tick(1);
    chk("sim on", sim_active_q, 1);
    for (int k = 1; k < 6; k++) begin
      primary_value = rnd(-200);
      tick(2);
      chk("ramp", ao_value_q, 16'(((k + 1) % 5) * 25));
    end
    tick(200);
    rdc(5'(9 + bin(primary_value, -200, 1000)), 0);
    sim_pv_mode = sim_off;
    sim_et_mode = sim_fixed;
    tc_icjc = 1'b1;
    pulse(sim_load);
    tick(3);
    chk("icjc", sim_active_q, 0);
    tc_icjc = 1'b0;
    pulse(sim_load);
    tick(3);
    chk("et sim", sim_active_q, 1);
    nrst = 1'b0;
    tick(2);
    {nrst, ld_idx, ld_data, primary_value, elec_temp} = {1'b1, 5'h05, seed, 32'h012c00fa};
    tick(1);
    chk("restart", sim_active_q, 0);
    pulse(ld_valid);
    rdc(5'h05, seed);
    $display("test simulation done");
    for (int i = 0; i < 7; i++) begin
      flt = 7'h01 << i;
      tick(2);
      chk("code", {flt_cls_q, flt_code_q}, {2'((i < 5) ? 1 : 2), codes[i]});
      chk("output", ao_mode_q, (i == 4) ? ao_under : ao_alarm);
      chk("stat", hart_stat_q[1:0], (i < 4) ? 1 : ((i > 4) ? 2 : 0));
      cnt = 0;
      repeat (16) begin
        tick(1);
        cnt += int'(led_red_q);
      end
      chk("red", cnt, (i < 5) ? 16 : 8);
    end
    flt = 7'h21;
    tick(2);
    chk("prio", {flt_cls_q, flt_code_q}, {2'h1, flt_ram});
    flt = 7'h00;
    elec_temp = 16'sh0275;
    tick(2);
    chk("et warn", {flt_cls_q, hart_stat_q[HS_W_ET], led_green_q}, 4'h3);
    elec_temp = 16'sh0276;
    tick(2);
    chk("et int", flt_code_q, flt_etemp);
    {elec_temp, temp_err_nv} = {16'sh00fa, 1'b1};
    tick(3);
    chk("latch", {temp_err_q, ao_mode_q}, {1'b1, ao_alarm});
    pulse(clr_req);
    tick(2);
    chk("nv hold", temp_err_q, 1);
    temp_err_nv = 1'b0;
    pulse(clr_req);
    tick(3);
    chk("unlatch", {temp_err_q, ao_mode_q}, {1'b0, ao_meas});
    sat_warn = 1'b1;
    for (int i = 0; i < 3; i++) begin
      primary_value = 16'(pvs[i]);
      tick(2);
      chk("warn", hart_stat_q[HS_W_PVLIM:HS_W_RANGE], 3'h7);
      chk("pv int", flt_code_q, (i == 2) ? flt_pvlim : flt_none);
      chk("pv out", {ao_mode_q, led_green_q}, {(i == 2) ? ao_alarm : ao_meas, i != 2});
    end
    {sat_warn, primary_value} = {1'b0, 16'sh012c};
    pulse(cfg_torn);
    tick(3);
    chk("torn", {cfg_err_q, hart_stat_q[HS_EFAULT], led_red_q}, 3'h7);
    pulse(cfg_reload_ok);
    tick(3);
    chk("reload", {cfg_err_q, hart_stat_q[HS_EFAULT], led_red_q}, 3'h0);
    $display("test diagnostics done");
    results();
  end
endmodule
